//--- ibr_pkg.sv
`default_nettype none
package ibr_pkg;
  // ------------------------------------------------------------------
  // Status codes
  // ------------------------------------------------------------------
  localparam logic [7:0] ST_IDLE = 8'hf8;
  localparam logic [7:0] ST_BUS_ERROR = 8'h00;
  localparam logic [7:0] ST_STARTED = 8'h08;
  localparam logic [7:0] ST_ARB_MT = 8'h38;
  localparam logic [7:0] ST_ARB_SR = 8'h68;
  localparam logic [7:0] ST_ARB_GC = 8'h78;
  localparam logic [7:0] ST_ARB_ST = 8'hb0;
  // ------------------------------------------------------------------
  // Link timing
  // ------------------------------------------------------------------
  localparam int LINK_PERIOD_PS = 30000;
  localparam int SCL_HALF_NS = 5000;
  localparam int SCL_HALF_CYC =
    (SCL_HALF_NS * 1000 + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
  localparam logic [1:0] PULSES_PER_TRY = 2'h2;
  localparam logic [3:0] FRAME_LAST_BIT = 4'h9;
  localparam logic [3:0] FRAME_FIRST_BIT = 4'h1;
  // ------------------------------------------------------------------
  // Link event toggles
  // ------------------------------------------------------------------
  localparam int EV_START = 0;
  localparam int EV_STOP = 1;
  localparam int EV_ERR = 2;
  localparam int EV_DONE = 3;
  typedef enum logic [2:0] {
    C_IDLE = 3'b000,
    C_MASTER = 3'b001,
    C_SLAVE = 3'b010,
    C_WAIT = 3'b011,
    C_START = 3'b100
  } ibr_core_t;
  typedef enum logic [1:0] {
    L_IDLE = 2'b00,
    L_PULSE = 2'b01,
    L_START = 2'b10,
    L_HOLD = 2'b11
  } ibr_link_t;
endpackage : ibr_pkg
`default_nettype wire

//--- ibr_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ibr_link_if;
  logic cmdStart;
  logic runEn;
  logic [3:0] evTgl;
  logic busBusy;
  modport core (output cmdStart, output runEn, input evTgl, input busBusy);
  modport link (input cmdStart, input runEn, output evTgl, output busBusy);
endinterface : ibr_link_if
`default_nettype wire

//--- ibr_link.sv
`timescale 1ns/1ps
`default_nettype none
module ibr_link #(
  parameter int HALF_CYC = ibr_pkg::SCL_HALF_CYC
) (
  input wire logic linkClk,
  input wire logic rst,
  input wire logic sdaIn,
  input wire logic sclIn,
  output logic sdaOe,
  output logic sclOe,
  ibr_link_if.link lnk
);
  import ibr_pkg::*;
  localparam int CW = $clog2(HALF_CYC + 1);
  if (HALF_CYC < 2) begin : g_badHalf
    $error("HALF_CYC must be at least two");
  end
  logic [1:0] rstSync, cmdSync, runSync;
  logic [2:0] sdaSync, sclSync;
  logic [CW-1:0] timer_r;
  logic [1:0] pulses_r;
  logic [3:0] bitCnt_r;
  logic phase_r, busy_r, tglStart, tglStop, tglErr, tglDone;
  ibr_link_t state_r;
  logic lrst, run, cmd, startCond, stopCond, sclRise, sclFall, timeUp;

  // Reset, commands and both bus lines all arrive from other domains.
  always_ff @(posedge linkClk) begin
    rstSync <= {rstSync[0], rst};
    cmdSync <= {cmdSync[0], lnk.cmdStart};
    runSync <= {runSync[0], lnk.runEn};
    sdaSync <= {sdaSync[1:0], sdaIn}; // R21
    sclSync <= {sclSync[1:0], sclIn}; // R21
  end
  assign lrst = rstSync[1];
  assign run = runSync[1];
  assign cmd = cmdSync[1];
  assign startCond = sclSync[1] & sclSync[2] & sdaSync[2] & ~sdaSync[1];
  assign stopCond = sclSync[1] & sclSync[2] & ~sdaSync[2] & sdaSync[1];
  assign sclRise = sclSync[1] & ~sclSync[2];
  assign sclFall = ~sclSync[1] & sclSync[2];
  assign timeUp = (timer_r == '0);
  assign lnk.evTgl = {tglDone, tglErr, tglStop, tglStart};
  assign lnk.busBusy = busy_r;

  // ------------------------------------------------------------------
  // Bus monitor
  // ------------------------------------------------------------------
  always_ff @(posedge linkClk) begin
    if (lrst) begin
      busy_r <= 1'b0;
      bitCnt_r <= '0;
      tglStart <= 1'b0;
      tglStop <= 1'b0;
      tglErr <= 1'b0;
    end else if (run) begin
      if (startCond) begin
        busy_r <= 1'b1;
        bitCnt_r <= '0;
        tglStart <= ~tglStart;
      end else if (stopCond) begin
        busy_r <= 1'b0;
        bitCnt_r <= '0;
        tglStop <= ~tglStop;
      end else if (sclRise && busy_r && bitCnt_r != FRAME_LAST_BIT) begin
        bitCnt_r <= bitCnt_r + 1'b1;
      end else if (sclFall && bitCnt_r == FRAME_LAST_BIT) begin
        bitCnt_r <= '0;
      end
      // The first high SCL of a frame is where a repeated START or a STOP
      // legally sits, so only a condition under a later bit is misplaced.
      // A condition under the first data bit itself passes unflagged.
      if ((startCond || stopCond) && busy_r &&
          bitCnt_r > FRAME_FIRST_BIT) begin
        tglErr <= ~tglErr; // R2
      end
    end
  end

  // ------------------------------------------------------------------
  // Start and pulse sequencer
  // ------------------------------------------------------------------
  always_ff @(posedge linkClk) begin
    if (lrst) begin
      state_r <= L_IDLE;
      sdaOe <= 1'b0;
      sclOe <= 1'b0;
      timer_r <= '0;
      pulses_r <= '0;
      phase_r <= 1'b0;
      tglDone <= 1'b0;
    end else if (run) begin
      if (!timeUp) begin
        timer_r <= timer_r - 1'b1;
      end
      unique case (state_r)
        L_IDLE: begin
          pulses_r <= '0;
          phase_r <= 1'b0;
          // A low SCL held by someone else just waits here.
          if (cmd && sclSync[1]) begin // R19
            timer_r <= CW'(HALF_CYC - 1);
            if (sdaSync[1]) begin
              sdaOe <= 1'b1; // R17
              state_r <= L_START;
            end else begin
              sclOe <= 1'b1; // R15 R18
              state_r <= L_PULSE;
            end
          end
        end
        L_PULSE: begin
          if (!cmd) begin
            sclOe <= 1'b0;
            state_r <= L_IDLE;
          end else if (timeUp && !phase_r) begin
            sclOe <= 1'b0;
            phase_r <= 1'b1;
            timer_r <= CW'(HALF_CYC - 1);
          end else if (timeUp && sclSync[1]) begin
            phase_r <= 1'b0;
            if (pulses_r == PULSES_PER_TRY - 1'b1) begin
              state_r <= L_IDLE; // R16
            end else begin
              pulses_r <= pulses_r + 1'b1;
              sclOe <= 1'b1;
              timer_r <= CW'(HALF_CYC - 1);
            end
          end
        end
        L_START: begin
          if (timeUp || !cmd) begin
            sclOe <= 1'b1;
            timer_r <= CW'(HALF_CYC - 1);
            state_r <= L_HOLD;
            if (cmd) begin
              tglDone <= ~tglDone;
            end
          end
        end
        L_HOLD: begin
          // SDA is let go only under a low SCL, so no STOP appears.
          if (sdaOe && timeUp) begin
            sdaOe <= 1'b0; // R7
          end else if (!sdaOe && !cmd) begin
            sclOe <= 1'b0;
            state_r <= L_IDLE;
          end
        end
      endcase
    end
  end

  default clocking cb @(posedge linkClk); endclocking
  default disable iff (lrst);
  property p_noOwnStop;
    $fell(sdaOe) |-> sclOe;
  endproperty
  a_noOwnStop: assert property (p_noOwnStop) // R7
    else $error("SDA released while SCL was free");
  property p_pulseSdaFree;
    state_r == L_PULSE |-> !sdaOe;
  endproperty
  a_pulseSdaFree: assert property (p_pulseSdaFree) // R15
    else $error("SDA driven during extra clock pulses");
  property p_pairRetry;
    state_r == L_PULSE |-> pulses_r < PULSES_PER_TRY;
  endproperty
  a_pairRetry: assert property (p_pairRetry) // R16
    else $error("More than two pulses before a start retry");
endmodule : ibr_link
`default_nettype wire

//--- ibr_top.sv
// Behaviour
// R1: With the interrupt flag clear the status output reads 0xF8.
// R2: START or STOP inside an address, data or acknowledge bit is a bus error.
// R3: Bus errors count only while master or addressed slave.
// R4: Bus error: not-addressed slave, release lines, set flag, status 0x00.
// R5: An undefined internal state also reports status 0x00.
// R6: Stop request plus flag clear recovers; only the stop request clears.
// R7: Recovery releases SDA and SCL without putting a STOP on the bus.
// R8: Foreign repeated START before ours: release bus, raise no interrupt.
// R9: After the other master's STOP, send START and report 0x08.
// R10: Arbitration loss reports 0x38, 0x68, 0x78 or 0xB0.
// R11: Start request during arbitration loss: START when free, report 0x08.
// R12: Software forces access when a start request stays unserved too long.
// R13: Stop with start pending acts as a received STOP, no STOP sent.
// R14: Forced access clears the stop request in hardware.
// R15: Free bus but SDA low: send extra SCL pulses instead of START.
// R16: Retry the START after every two extra SCL pulses.
// R17: Once SDA is free, send START, report 0x08, carry on alone.
// R18: Forced access and repeated START use the same pulse recovery.
// R19: A held-low SCL is not recovered; its holder must release it.
// R20: Idle with acknowledge set: match own address, general call if enabled.
// R21: SDA and SCL are synchronised before condition detection.
`timescale 1ns/1ps
`default_nettype none
module ibr_top #(
  parameter int HALF_CYC = ibr_pkg::SCL_HALF_CYC
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic linkClk,
  input wire logic sdaIn,
  input wire logic sclIn,
  output logic sdaOut,
  output logic sdaOe,
  output logic sclOut,
  output logic sclOe,
  input wire logic swSetStart,
  input wire logic swClrStart,
  input wire logic swSetStop,
  input wire logic swSetAck,
  input wire logic swClrAck,
  input wire logic swClrInt,
  input wire logic ownAddrGc,
  input wire logic inMaster,
  input wire logic inAddrSlave,
  input wire logic rsPending,
  input wire logic arbLost,
  input wire logic [7:0] arbCode,
  input wire logic undefState,
  output logic startReqFlag,
  output logic stopReqFlag,
  output logic serIntFlag,
  output logic assertAckFlag,
  output logic [7:0] statusCode,
  output logic ownAddrMatchEn,
  output logic genCallMatchEn,
  output logic masterStarted,
  output logic busRelease
);
  import ibr_pkg::*;

  // ------------------------------------------------------------------
  // Link side
  // ------------------------------------------------------------------
  ibr_link_if lnk ();
  ibr_link #(
    .HALF_CYC(HALF_CYC)
  ) u_link (
    .linkClk(linkClk),
    .rst(rst),
    .sdaIn(sdaIn),
    .sclIn(sclIn),
    .sdaOe(sdaOe),
    .sclOe(sclOe),
    .lnk(lnk.link)
  );

  ibr_core_t state_r;
  logic [3:0] tglS1, tglS2, tglS3;
  logic busyS1, busyS2;
  logic cmdStart_r, runEn_r, pinLow_r;
  logic sta_r, sto_r, aa_r, si_r;
  logic [7:0] code_r, statusCode_r;
  logic ownAddr_r, genCall_r, started_r, release_r;
  logic [3:0] ev;
  logic stateBad, involved, busErr, arbEvt, forceFree, busFree;
  logic startGo, rsLost, started, recover;

  function automatic logic isArbCode(input logic [7:0] code);
    return code == ST_ARB_MT || code == ST_ARB_SR ||
           code == ST_ARB_GC || code == ST_ARB_ST;
  endfunction : isArbCode

  assign lnk.cmdStart = cmdStart_r;
  assign lnk.runEn = runEn_r;
  assign sdaOut = pinLow_r;
  assign sclOut = pinLow_r;
  assign startReqFlag = sta_r;
  assign stopReqFlag = sto_r;
  assign serIntFlag = si_r;
  assign assertAckFlag = aa_r;
  assign statusCode = statusCode_r;
  assign ownAddrMatchEn = ownAddr_r;
  assign genCallMatchEn = genCall_r;
  assign masterStarted = started_r;
  assign busRelease = release_r;

  // ------------------------------------------------------------------
  // Crossing from the link domain
  // ------------------------------------------------------------------
  // Events travel as toggles, so a frozen core still sees them later.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      tglS1 <= '0;
      tglS2 <= '0;
      tglS3 <= '0;
      busyS1 <= 1'b0;
      busyS2 <= 1'b0;
    end else if (ce) begin
      tglS1 <= lnk.evTgl;
      tglS2 <= tglS1;
      tglS3 <= tglS2;
      busyS1 <= lnk.busBusy;
      busyS2 <= busyS1;
    end
  end
  assign ev = tglS2 ^ tglS3;

  // The link is frozen with the core by following the enable level.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      runEn_r <= 1'b0;
      pinLow_r <= 1'b0;
    end else begin
      runEn_r <= ce;
      pinLow_r <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Event decode
  // ------------------------------------------------------------------
  assign stateBad = !(state_r inside {C_IDLE, C_MASTER, C_SLAVE, C_WAIT,
                                      C_START});
  assign involved = state_r == C_MASTER || state_r == C_SLAVE ||
                    inMaster || inAddrSlave; // R3
  assign busErr = (ev[EV_ERR] && involved) || undefState ||
                  stateBad; // R2 R5
  assign arbEvt = arbLost && isArbCode(arbCode) && !busErr; // R10
  // A start request met by a stop request overrides a busy bus.
  assign forceFree = sta_r && sto_r; // R13
  assign busFree = !busyS2 || forceFree;
  assign startGo = !busErr && !arbEvt && busFree &&
                   ((state_r == C_IDLE && sta_r && !si_r) ||
                    state_r == C_WAIT); // R9 R11
  assign rsLost = state_r == C_MASTER && ev[EV_START] && rsPending &&
                  !busErr && !arbEvt; // R8
  assign started = state_r == C_START && ev[EV_DONE] && !busErr &&
                   !arbEvt;
  assign recover = state_r == C_IDLE && sto_r && !sta_r && !si_r; // R6

  // ------------------------------------------------------------------
  // Mode state
  // ------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_r <= C_IDLE;
      cmdStart_r <= 1'b0;
    end else if (ce) begin
      if (busErr || arbEvt) begin
        // Dropping the command makes the link let go of both lines.
        state_r <= C_IDLE; // R4 R7
        cmdStart_r <= 1'b0;
      end else begin
        unique case (state_r)
          C_IDLE: begin
            if (startGo) begin
              state_r <= C_START;
              cmdStart_r <= 1'b1; // R11 R18
            end else if (inAddrSlave) begin
              state_r <= C_SLAVE;
            end
          end
          C_MASTER: begin
            if (rsLost) begin
              state_r <= C_WAIT; // R8
            end else if (!inMaster && !si_r) begin
              state_r <= C_IDLE;
            end
          end
          C_SLAVE: begin
            if (!inAddrSlave) begin
              state_r <= C_IDLE;
            end
          end
          C_WAIT: begin
            if (startGo) begin
              state_r <= C_START; // R9
              cmdStart_r <= 1'b1;
            end
          end
          C_START: begin
            if (started) begin
              state_r <= C_MASTER; // R17
              cmdStart_r <= 1'b0;
            end
          end
          default: begin
            state_r <= C_IDLE;
            cmdStart_r <= 1'b0;
          end
        endcase
      end
    end
  end

  // ------------------------------------------------------------------
  // Control flags
  // ------------------------------------------------------------------
  // Software sets win over the hardware clear of the stop request.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sta_r <= 1'b0;
      sto_r <= 1'b0;
      aa_r <= 1'b0;
    end else if (ce) begin
      if (swSetStart) begin
        sta_r <= 1'b1;
      end else if (swClrStart) begin
        sta_r <= 1'b0;
      end
      if (swSetStop) begin
        sto_r <= 1'b1;
      end else if ((startGo && forceFree) || recover) begin
        sto_r <= 1'b0; // R6 R14
      end
      if (swSetAck) begin
        aa_r <= 1'b1;
      end else if (swClrAck) begin
        aa_r <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // Interrupt flag and status code
  // ------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      si_r <= 1'b0;
      code_r <= ST_IDLE;
    end else if (ce) begin
      if (busErr) begin
        si_r <= 1'b1; // R4 R5
        code_r <= ST_BUS_ERROR;
      end else if (arbEvt) begin
        si_r <= 1'b1; // R10
        code_r <= arbCode;
      end else if (started) begin
        si_r <= 1'b1; // R9 R11 R17
        code_r <= ST_STARTED;
      end else if (swClrInt) begin
        si_r <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      statusCode_r <= ST_IDLE;
      ownAddr_r <= 1'b0;
      genCall_r <= 1'b0;
      started_r <= 1'b0;
      release_r <= 1'b0;
    end else if (ce) begin
      statusCode_r <= si_r ? code_r : ST_IDLE; // R1
      ownAddr_r <= state_r == C_IDLE && aa_r; // R20
      genCall_r <= state_r == C_IDLE && aa_r && ownAddrGc; // R20
      started_r <= started;
      release_r <= busErr || arbEvt || rsLost; // R4 R8
    end
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  default clocking cc @(posedge core_clk); endclocking
  default disable iff (rst);
  property p_idleCode;
    ce && !si_r |=> statusCode_r == ST_IDLE;
  endproperty
  a_idleCode: assert property (p_idleCode) // R1
    else $error("Status not 0xF8 with interrupt flag clear");
  property p_busError;
    ce && busErr |=> si_r && code_r == ST_BUS_ERROR &&
      state_r == C_IDLE && !cmdStart_r && release_r;
  endproperty
  a_busError: assert property (p_busError) // R4
    else $error("Bus error not handled");
  property p_ignoreUninvolved;
    ce && ev[EV_ERR] && !involved && !undefState && !stateBad &&
      !arbEvt && !started |=> code_r == $past(code_r);
  endproperty
  a_ignoreUninvolved: assert property (p_ignoreUninvolved) // R3
    else $error("Bus error taken while not involved");
  property p_recover;
    ce && recover && !swSetStop && !swSetStart && !swClrStart &&
      !swSetAck && !swClrAck |=> !sto_r && sta_r == $past(sta_r) &&
      aa_r == $past(aa_r);
  endproperty
  a_recover: assert property (p_recover) // R6
    else $error("Recovery touched other flags or kept stop");
  property p_rsLost;
    ce && rsLost |=> state_r == C_WAIT && !(si_r && !$past(si_r));
  endproperty
  a_rsLost: assert property (p_rsLost) // R8
    else $error("Repeated start collision mishandled");
  property p_started;
    ce && started |=> si_r && code_r == ST_STARTED && state_r == C_MASTER;
  endproperty
  a_started: assert property (p_started) // R17
    else $error("Start done without status 0x08");
  property p_arbCode;
    ce && arbEvt |=> si_r && code_r == $past(arbCode) &&
      isArbCode(code_r);
  endproperty
  a_arbCode: assert property (p_arbCode) // R10
    else $error("Arbitration loss status wrong");
  property p_forced;
    ce && forceFree && startGo && !swSetStop |=>
      state_r == C_START && !sto_r && cmdStart_r;
  endproperty
  a_forced: assert property (p_forced) // R13
    else $error("Forced access did not start or clear stop");
  property p_recog;
    ce && state_r == C_IDLE |=> ownAddrMatchEn == $past(aa_r) &&
      genCallMatchEn == ($past(aa_r) && $past(ownAddrGc));
  endproperty
  a_recog: assert property (p_recog) // R20
    else $error("Address recognition enable wrong");
  c_busError: cover property (ce && busErr && involved);
  c_arbRetry: cover property (ce && arbEvt ##[1:400] (ce && started));
  c_rsLost: cover property (ce && rsLost);
  c_forced: cover property (ce && startGo && forceFree);
endmodule : ibr_top
`default_nettype wire

//--- ibr_bus_peer.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------------
// Other bus parties: open-drain lines with pull-ups
// ------------------------------------------------------------------
module ibr_bus_peer (
  input wire logic devSdaOe,
  input wire logic devSclOe,
  output logic sdaLine,
  output logic sclLine
);
  logic pSda = 1'b0;
  logic pScl = 1'b0;
  int stopCnt = 0;
  // A released line floats to the pull-up level, never the old value.
  assign sdaLine = !(devSdaOe || pSda);
  assign sclLine = !(devSclOe || pScl);
  always @(posedge sdaLine) begin
    if (sclLine) begin
      stopCnt++;
    end
  end
  // Each pair in v is {sda pulled, scl pulled}, most significant first.
  task automatic seq(input logic [7:0] v);
    for (int i = 3; i >= 0; i--) begin
      #200;
      pSda = v[2*i+1];
      pScl = v[2*i];
    end
    #200;
  endtask : seq
endmodule : ibr_bus_peer
`default_nettype wire

//--- testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ibr_pkg::*;
  localparam logic [7:0] START = 8'hb4;
  localparam logic [7:0] STOP = 8'h78;
  localparam logic [7:0] PULSE = 8'h40;
  logic core_clk = 1'b0;
  logic linkClk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic swSetStart, swClrStart, swSetStop, swSetAck, swClrAck, swClrInt;
  logic ownAddrGc, inMaster, inAddrSlave, rsPending, arbLost, undefState;
  logic [7:0] arbCode;
  wire logic sdaIn, sclIn;
  logic sdaOut, sdaOe, sclOut, sclOe, startReqFlag, stopReqFlag;
  logic serIntFlag, assertAckFlag, ownAddrMatchEn, genCallMatchEn;
  logic masterStarted, busRelease;
  logic [7:0] statusCode;
  int error_cnt = 0;
  int samples_checked = 0;
  int seed = 38;
  int cycles = 0;
  int pulses = 0;
  int pulsesAtStart = 0;
  int relCnt = 0;
  int mark;
  logic [7:0] arbTab [4] = '{ST_ARB_MT, ST_ARB_SR, ST_ARB_GC, ST_ARB_ST};
  always #5 core_clk = ~core_clk;
  initial begin
    #3.7;
    forever #15 linkClk = ~linkClk;
  end
  ibr_top #(.HALF_CYC(4)) ibr_top_inst (.*);
  ibr_bus_peer ibr_bus_peer_inst (.devSdaOe(sdaOe), .devSclOe(sclOe),
    .sdaLine(sdaIn), .sclLine(sclIn));
  always @(posedge sclOe) pulses++;
  always @(posedge sdaOe) pulsesAtStart = pulses;
  always @(posedge core_clk) begin
    cycles++;
    if (busRelease === 1'b1) begin
      relCnt++;
    end
    if (cycles == 60000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  task automatic report_and_stop();
    $display("Checks %0d, errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : cyc
  // Strobes are held one edge, then a free edge follows.
  task automatic sw(input logic [5:0] m);
    {swClrInt, swClrAck, swSetAck, swSetStop, swClrStart, swSetStart} = m;
    cyc(1);
    {swClrInt, swClrAck, swSetAck, swSetStop, swClrStart, swSetStart} = 0;
    cyc(1);
  endtask : sw
  task automatic waitSi(input logic [7:0] exp);
    int n;
    n = 0;
    while (serIntFlag !== 1'b1 && n < 4000) begin
      cyc(1);
      n++;
    end
    chk(masterStarted, exp == ST_STARTED);
    cyc(1);
    chk(statusCode, exp);
  endtask : waitSi
  task automatic waitFree();
    int n;
    n = 0;
    while ((sdaOe | sclOe) !== 1'b0 && n < 2000) begin
      cyc(1);
      n++;
    end
    chk({sdaOe, sclOe}, 8'h00);
  endtask : waitFree
  task automatic ownStart();
    sw(6'h01);
    waitSi(ST_STARTED);
    sw(6'h22);
    chk(statusCode, ST_IDLE);
    waitFree();
  endtask : ownStart
  task automatic strobeIn(input int which);
    if (which == 0) begin
      arbLost = 1'b1;
    end else begin
      undefState = 1'b1;
    end
    cyc(1);
    arbLost = 1'b0;
    undefState = 1'b0;
  endtask : strobeIn
  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    {swClrInt, swClrAck, swSetAck, swSetStop, swClrStart, swSetStart} = 0;
    {inMaster, inAddrSlave, rsPending, arbLost, undefState} = 5'h00;
    ownAddrGc = 1'b0;
    arbCode = 8'h00;
    // Longer than three cycles so the link domain also sees reset.
    cyc(12);
    rst = 1'b0;
    cyc(2);
    chk(statusCode, ST_IDLE);
    ownAddrGc = $random(seed);
    sw(6'h08);
    chk(ownAddrMatchEn, 8'h01);
    chk(genCallMatchEn, ownAddrGc);
    ownStart();
    ibr_bus_peer_inst.seq(STOP);
    ibr_bus_peer_inst.seq(START);
    ibr_bus_peer_inst.seq(PULSE);
    ibr_bus_peer_inst.seq(STOP);
    chk(serIntFlag, 8'h00);
    // A frozen core must not take a strobe.
    ce = 1'b0;
    sw(6'h04);
    chk(stopReqFlag, 8'h00);
    ce = 1'b1;
    ownStart();
    if ($random(seed) & 1) inMaster = 1'b1;
    else inAddrSlave = 1'b1;
    mark = relCnt;
    ibr_bus_peer_inst.seq(PULSE);
    ibr_bus_peer_inst.seq(START);
    waitSi(ST_BUS_ERROR);
    cyc(10);
    chk({sdaOut, sclOut, sdaOe, sclOe, relCnt > mark}, 8'h01);
    {inMaster, inAddrSlave} = 2'b00;
    mark = ibr_bus_peer_inst.stopCnt;
    sw(6'h04);
    sw(6'h20);
    cyc(3);
    chk({stopReqFlag, assertAckFlag, startReqFlag}, 8'h02);
    chk(ibr_bus_peer_inst.stopCnt - mark, 8'h00);
    ibr_bus_peer_inst.seq(STOP);
    inMaster = 1'b1;
    strobeIn(1);
    waitSi(ST_BUS_ERROR);
    inMaster = 1'b0;
    sw(6'h04);
    sw(6'h20);
    for (int i = 0; i < 4; i++) begin
      arbCode = arbTab[i];
      strobeIn(0);
      waitSi(arbTab[i]);
      sw(6'h20);
    end
    ibr_bus_peer_inst.seq(START);
    mark = $random(seed) & 3;
    arbCode = arbTab[mark];
    strobeIn(0);
    waitSi(arbTab[mark]);
    sw(6'h01);
    sw(6'h20);
    cyc(100);
    chk(serIntFlag, 8'h00);
    ibr_bus_peer_inst.seq(STOP);
    waitSi(ST_STARTED);
    sw(6'h22);
    waitFree();
    ibr_bus_peer_inst.seq(STOP);
    ibr_bus_peer_inst.seq(START);
    sw(6'h01);
    // Start stays unserved on a busy bus, so access is forced.
    cyc(200);
    chk(serIntFlag, 8'h00);
    sw(6'h04);
    chk(stopReqFlag, 8'h00);
    waitSi(ST_STARTED);
    sw(6'h22);
    waitFree();
    ibr_bus_peer_inst.seq(STOP);
    ibr_bus_peer_inst.pSda = 1'b1;
    pulses = 0;
    sw(6'h01);
    mark = 0;
    while (pulses < 3 && mark < 4000) begin
      cyc(1);
      mark++;
    end
    ibr_bus_peer_inst.pSda = 1'b0;
    waitSi(ST_STARTED);
    chk(pulsesAtStart[7:0], 8'h04);
    // The engine still runs the transfer, so the core stays master.
    inMaster = 1'b1;
    rsPending = 1'b1;
    sw(6'h22);
    waitFree();
    mark = relCnt;
    // The foreign START sits at the first high SCL, a legal position.
    ibr_bus_peer_inst.seq(START);
    cyc(50);
    chk({serIntFlag, relCnt > mark}, 8'h01);
    rsPending = 1'b0;
    // The engine has let go, so the other master's frame is not ours.
    inMaster = 1'b0;
    ibr_bus_peer_inst.seq(STOP);
    waitSi(ST_STARTED);
    sw(6'h22);
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
